//--- verilog/pief_top.sv
// Peripheral interrupt enables, first flag register and request logic.
// Assumes an APB master and event sources on CLOCK.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module pief_top
    import pief_pkg::*;
(
    input  wire logic              CLOCK,
    input  wire logic              ARST_N,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              SER_TX_DONE,
    input  wire logic              SER_RX_LOAD,
    input  wire logic [7:0]        SER_RX_DATA_IN,
    input  wire logic              BUS_COLLISION,
    input  wire logic              SYNC_PORT_EVENT,
    input  wire logic              TIMER_B_MATCH,
    input  wire logic              TIMER_A_ROLL,
    input  wire logic [7:0]        FLAG_TWO,
    output logic [7:0]             SER_TX_DATA,
    output logic                   SER_TX_LOAD,
    output logic                   IRQ_REQ,
    output logic                   IRQ_EVENT
);
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic [7:0]       enable_two_reg;
    logic [7:0]       enable_one_reg;
    logic             global_irq_en_reg;
    logic             periph_master_en_reg;
    logic [7:0]       rx_data_reg;
    logic [7:0]       tx_data_reg;
    logic             tx_load_reg;
    logic [EVT_W-1:0] evt_enable_reg;
    logic [31:0]      prdata_reg;
    logic             pready_reg;
    logic             pslverr_reg;
    logic             irq_req_reg;
    logic             irq_event_reg;

    // Bus qualification
    wire access   = PSEL & PENABLE;
    wire done     = access & pready_reg;
    wire wr_done  = done & PWRITE;
    wire rd_done  = done & ~PWRITE;

    wire sel_en2  = hit(PADDR, OFF_ENABLE_TWO);
    wire sel_flg1 = hit(PADDR, OFF_FLAG_ONE);
    wire sel_glb  = hit(PADDR, OFF_GLOBAL);
    wire sel_en1  = hit(PADDR, OFF_ENABLE_ONE);
    wire sel_tx   = hit(PADDR, OFF_TX_DATA);
    wire sel_rx   = hit(PADDR, OFF_RX_DATA);
    wire sel_est  = hit(PADDR, OFF_EVT_STATUS);
    wire sel_ecl  = hit(PADDR, OFF_EVT_CLEAR);
    wire sel_een  = hit(PADDR, OFF_EVT_ENABLE);
    wire mapped   = sel_en2 | sel_flg1 | sel_glb | sel_en1 | sel_tx
                  | sel_rx | sel_est | sel_ecl | sel_een;

    wire tx_write = wr_done & sel_tx;
    wire rx_read  = rd_done & sel_rx;

    // Event vector and flag bank
    wire [EVT_W-1:0] evt = {SER_TX_DONE, SER_RX_LOAD, BUS_COLLISION,
                            SYNC_PORT_EVENT, TIMER_B_MATCH, TIMER_A_ROLL};
    wire [7:0] flag_set  = {evt[EVT_TX], evt[EVT_RX], evt[EVT_COLL],
                            evt[EVT_SYNC], 2'b00, evt[EVT_TB],
                            evt[EVT_TA]};
    wire [7:0] flag_clr  = {tx_write, rx_read, 6'h00};
    wire [7:0] flag_one;

    pief_sticky #(
        .W     (8),
        .WMASK (FLAG_ONE_WMASK)
    ) u_flag_one (
        .clk      (CLOCK),
        .arst_n   (ARST_N),
        .set_bits (flag_set),
        .clr_bits (flag_clr),
        .wr_en    (wr_done & sel_flg1),
        .wr_val   (PWDATA[7:0]),
        .flags    (flag_one)
    );

    // Event status, write-one-to-clear
    wire [EVT_W-1:0] evt_status;

    pief_sticky #(
        .W     (EVT_W),
        .WMASK (RST_EVT)
    ) u_evt_status (
        .clk      (CLOCK),
        .arst_n   (ARST_N),
        .set_bits (evt),
        .clr_bits (wr_done & sel_ecl ? PWDATA[EVT_W-1:0] : RST_EVT),
        .wr_en    (1'b0),
        .wr_val   (RST_EVT),
        .flags    (evt_status)
    );

    // Request gating
    wire pending    = |((flag_one & enable_one_reg)
                      | (FLAG_TWO & enable_two_reg));
    wire irq_next   = global_irq_en_reg & periph_master_en_reg
                    & pending;
    wire evt_next   = |(evt_status & evt_enable_reg);

    // Read selection
    wire [7:0] glb_rd = {global_irq_en_reg, periph_master_en_reg, 6'h00};
    wire [7:0] rd_byte =
          sel_en2  ? (enable_two_reg & ENABLE_TWO_MASK)
        : sel_flg1 ? flag_one
        : sel_glb  ? glb_rd
        : sel_en1  ? enable_one_reg
        : sel_tx   ? tx_data_reg
        : sel_rx   ? rx_data_reg
        : sel_est  ? {2'b00, evt_status}
        : sel_een  ? {2'b00, evt_enable_reg}
        : RST_BYTE;

    // APB handshake, one wait cycle
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end
        else
        begin
            pready_reg  <= access & ~pready_reg;
            pslverr_reg <= access & ~pready_reg & ~mapped;
            prdata_reg  <= (access & ~pready_reg & ~PWRITE)
                         ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // Software registers
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            enable_two_reg       <= RST_BYTE;
            enable_one_reg       <= RST_BYTE;
            global_irq_en_reg    <= 1'b0;
            periph_master_en_reg <= 1'b0;
            evt_enable_reg       <= RST_EVT;
        end
        else if (wr_done)
        begin
            if (sel_en2)
                enable_two_reg <= PWDATA[7:0] & ENABLE_TWO_MASK;
            if (sel_en1)
                enable_one_reg <= PWDATA[7:0];
            if (sel_glb)
            begin
                global_irq_en_reg    <= PWDATA[GLOBAL_EN_BIT];
                periph_master_en_reg <= PWDATA[PERIPH_EN_BIT];
            end
            if (sel_een)
                evt_enable_reg <= PWDATA[EVT_W-1:0];
        end
    end

    // Serial data holding registers
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            tx_data_reg <= RST_BYTE;
            tx_load_reg <= 1'b0;
            rx_data_reg <= RST_BYTE;
        end
        else
        begin
            tx_load_reg <= tx_write;
            if (tx_write)
                tx_data_reg <= PWDATA[7:0];
            if (SER_RX_LOAD)
                rx_data_reg <= SER_RX_DATA_IN;
        end
    end

    // Interrupt outputs
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            irq_req_reg   <= 1'b0;
            irq_event_reg <= 1'b0;
        end
        else
        begin
            irq_req_reg   <= irq_next;
            irq_event_reg <= evt_next;
        end
    end

    assign PRDATA      = prdata_reg;
    assign PREADY      = pready_reg;
    assign PSLVERR     = pslverr_reg;
    assign SER_TX_DATA = tx_data_reg;
    assign SER_TX_LOAD = tx_load_reg;
    assign IRQ_REQ     = irq_req_reg;
    assign IRQ_EVENT   = irq_event_reg;

    // Checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);

    sequence s_setup;
        PSEL && !PENABLE;
    endsequence

    sequence s_access;
        PSEL && PENABLE;
    endsequence

    chk_apb_wait: assert property (
        s_setup ##1 s_access |-> !PREADY ##1 (PREADY || !PENABLE))
        else $error("APB ready not after one wait cycle");

    chk_master_gate: assert property (
        !periph_master_en_reg |=> !IRQ_REQ)
        else $error("request raised without peripheral master enable");

    chk_global_gate: assert property (
        !global_irq_en_reg |=> !IRQ_REQ)
        else $error("request raised without global enable");

    chk_req_cause: assert property (
        IRQ_REQ |-> $past(pending) && $past(global_irq_en_reg))
        else $error("request without enabled pending flag");

    chk_enable_write: assert property (
        wr_done && sel_en2 |=> enable_two_reg == ($past(PWDATA[7:0])
                                                  & ENABLE_TWO_MASK))
        else $error("enable-two write not stored");

    chk_rsvd_zero: assert property (
        enable_two_reg[RSVD_EN_BIT] == 1'b0)
        else $error("reserved enable bit set");

    chk_event_sets: assert property (
        TIMER_A_ROLL |=> flag_one[TA_FLAG_BIT])
        else $error("timer A rollover flag not set");

    chk_tx_clear: assert property (
        tx_write && !SER_TX_DONE |=> !flag_one[TX_FLAG_BIT] && SER_TX_LOAD)
        else $error("transmit flag not cleared on data write");

    chk_rx_clear: assert property (
        rx_read && !SER_RX_LOAD |=> !flag_one[RX_FLAG_BIT])
        else $error("receive flag not cleared on data read");

    chk_coll_flag: assert property (
        BUS_COLLISION |=> flag_one[COLL_FLAG_BIT])
        else $error("collision flag not set");

    chk_sync_flag: assert property (
        SYNC_PORT_EVENT |=> flag_one[SYNC_FLAG_BIT])
        else $error("sync port flag not set");

    chk_tb_hold: assert property (
        flag_one[TB_FLAG_BIT] && !(wr_done && sel_flg1)
        |=> flag_one[TB_FLAG_BIT])
        else $error("timer B flag dropped without software clear");

    chk_ta_hold: assert property (
        flag_one[TA_FLAG_BIT] && !(wr_done && sel_flg1) |=>
        flag_one[TA_FLAG_BIT] [*2] or (wr_done && sel_flg1))
        else $error("timer A flag dropped without software clear");

    chk_tb_sets: assert property (
        TIMER_B_MATCH |=> flag_one[TB_FLAG_BIT])
        else $error("timer B match flag not set");

    chk_tx_sets: assert property (
        SER_TX_DONE |=> flag_one[TX_FLAG_BIT])
        else $error("transmit empty flag not set");

    chk_rx_capture: assert property (
        SER_RX_LOAD |=> flag_one[RX_FLAG_BIT]
                        && rx_data_reg == $past(SER_RX_DATA_IN))
        else $error("receive entry not captured");

    chk_flag_sw_set: assert property (
        wr_done && sel_flg1 && PWDATA[TA_FLAG_BIT]
        |=> flag_one[TA_FLAG_BIT])
        else $error("timer A flag not set by software write");

    chk_en2_hold: assert property (
        !(wr_done && sel_en2) |=> $stable(enable_two_reg))
        else $error("enable-two changed without a write");

    chk_irq_off: assert property (
        !pending |=> !IRQ_REQ)
        else $error("request raised with nothing pending");

    chk_slave_err: assert property (
        done |-> PSLVERR == !mapped)
        else $error("APB error response wrong");
endmodule

//--- verilog/pief_pkg.sv
// Constants for the peripheral interrupt enable and flag block.
// Assumes one core clock, APB register access, same-clock event pulses.
package pief_pkg;
    localparam int ADDR_W = 8;
    localparam int EVT_W  = 6;

    localparam logic [ADDR_W-1:0] OFF_ENABLE_TWO = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_FLAG_ONE   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_GLOBAL     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ENABLE_ONE = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_TX_DATA    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RX_DATA    = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_EVT_CLEAR  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_EVT_ENABLE = 8'h20;

    localparam logic [7:0] ENABLE_TWO_MASK = 8'hDF;
    localparam logic [7:0] FLAG_ONE_WMASK  = 8'h33;
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [EVT_W-1:0] RST_EVT   = 6'h00;

    localparam int GLOBAL_EN_BIT = 7;
    localparam int PERIPH_EN_BIT = 6;
    localparam int TX_FLAG_BIT   = 7;
    localparam int RX_FLAG_BIT   = 6;
    localparam int COLL_FLAG_BIT = 5;
    localparam int SYNC_FLAG_BIT = 4;
    localparam int TB_FLAG_BIT   = 1;
    localparam int TA_FLAG_BIT   = 0;
    localparam int RSVD_EN_BIT   = 5;

    localparam int EVT_TA   = 0;
    localparam int EVT_TB   = 1;
    localparam int EVT_SYNC = 2;
    localparam int EVT_COLL = 3;
    localparam int EVT_RX   = 4;
    localparam int EVT_TX   = 5;
endpackage

//--- verilog/pief_sticky.sv
// Sticky flag bank with masked software write and hardware clear.
// Assumes set, clear and write inputs are on the same clock.
`timescale 1ns/1ps
module pief_sticky
    import pief_pkg::*;
#(
    parameter int         W     = 8,
    parameter logic [W-1:0] WMASK = '0
)
(
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] set_bits,
    input  wire logic [W-1:0] clr_bits,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_val,
    output logic      [W-1:0] flags
);
    logic [W-1:0] flags_reg;
    logic [W-1:0] written;
    logic [W-1:0] flags_next;

    assign written    = wr_en ? ((wr_val & WMASK) | (flags_reg & ~WMASK))
                              : flags_reg;
    // Set wins over clear and over write
    assign flags_next = set_bits | (written & ~clr_bits);
    assign flags      = flags_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            flags_reg <= '0;
        else
            flags_reg <= flags_next;
    end
endmodule

//--- test/pief_src_model.sv
// Event source and second flag model for the interrupt block.
// Assumes the bench calls its tasks and shares the core clock.
`timescale 1ns/1ps
module pief_src_model
    import pief_pkg::*;
(
    input  wire logic             clk,
    output logic      [EVT_W-1:0] ev,
    output logic      [7:0]       rx_data,
    output logic      [7:0]       flag_two
);
    initial
    begin
        ev       = '0;
        rx_data  = 8'h00;
        flag_two = 8'h00;
    end
    // One-cycle event pulse
    task automatic fire(input int idx, input logic [7:0] d);
    begin
        @(posedge clk);
        ev[idx] <= 1'b1;
        rx_data <= d;
        @(posedge clk);
        ev      <= '0;
        rx_data <= ~d;
    end
    endtask
    // Second flag register level
    task automatic set_two(input logic [7:0] v);
    begin
        @(posedge clk);
        flag_two <= v;
    end
    endtask
endmodule

//--- test/testbench.sv
// Self-checking bench for the interrupt enable and flag block.
// Assumes the event source model and the APB map of the package.
`timescale 1ns/1ps
module testbench;
    import pief_pkg::*;
    logic              CLOCK, ARST_N, PSEL, PENABLE, PWRITE, err;
    logic              PREADY, PSLVERR, SER_TX_LOAD, IRQ_REQ, IRQ_EVENT;
    logic [ADDR_W-1:0] PADDR;
    logic [31:0]       PWDATA, PRDATA, rdat;
    logic [7:0]        SER_TX_DATA, rx_data, flag_two;
    logic [EVT_W-1:0]  ev;
    int                fail_count, checks, cycles;

    pief_src_model src (.clk(CLOCK), .ev(ev), .rx_data(rx_data),
                        .flag_two(flag_two));

    pief_top DUT (
        .CLOCK           (CLOCK),
        .ARST_N          (ARST_N),
        .PSEL            (PSEL),
        .PENABLE         (PENABLE),
        .PWRITE          (PWRITE),
        .PADDR           (PADDR),
        .PWDATA          (PWDATA),
        .PRDATA          (PRDATA),
        .PREADY          (PREADY),
        .PSLVERR         (PSLVERR),
        .SER_TX_DONE     (ev[EVT_TX]),
        .SER_RX_LOAD     (ev[EVT_RX]),
        .SER_RX_DATA_IN  (rx_data),
        .BUS_COLLISION   (ev[EVT_COLL]),
        .SYNC_PORT_EVENT (ev[EVT_SYNC]),
        .TIMER_B_MATCH   (ev[EVT_TB]),
        .TIMER_A_ROLL    (ev[EVT_TA]),
        .FLAG_TWO        (flag_two),
        .SER_TX_DATA     (SER_TX_DATA),
        .SER_TX_LOAD     (SER_TX_LOAD),
        .IRQ_REQ         (IRQ_REQ),
        .IRQ_EVENT       (IRQ_EVENT)
    );

    initial
    begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    task automatic end_of_test;
    begin
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask

    // Hang guard
    always @(posedge CLOCK)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // One APB transfer, held until PREADY is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
    begin
        @(posedge CLOCK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLOCK);
        end
        while (PREADY !== 1'b1);
        rdat = PRDATA;
        err  = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    begin
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    end
    endtask

    // Request level after the update has landed
    task automatic irq(input logic exp);
    begin
        repeat (2) @(negedge CLOCK);
        chk({31'h0, IRQ_REQ}, {31'h0, exp});
    end
    endtask

    task automatic t_reset;
    begin
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        irq(1'b0);
    end
    endtask

    task automatic t_enable_two;
    begin
        wr(8'h00, 32'hFF);
        rd(8'h00, 32'hDF);
        wr(8'h00, 32'h20);
        rd(8'h00, 32'h0);
    end
    endtask

    task automatic t_flags;
    begin
        src.fire(EVT_TA, 8'h00);
        src.fire(EVT_TB, 8'h00);
        src.fire(EVT_SYNC, 8'h00);
        src.fire(EVT_COLL, 8'h00);
        src.fire(EVT_RX, 8'h5A);
        src.fire(EVT_TX, 8'h00);
        rd(8'h04, 32'hF3);
        rd(8'h18, 32'h3F);
    end
    endtask

    task automatic t_clear;
    begin
        wr(8'h10, 32'hA5);
        @(negedge CLOCK);
        chk({31'h0, SER_TX_LOAD}, 32'h1);
        @(negedge CLOCK);
        chk({31'h0, SER_TX_LOAD}, 32'h0);
        chk({24'h0, SER_TX_DATA}, 32'hA5);
        rd(8'h10, 32'hA5);
        rd(8'h04, 32'h73);
        rd(8'h14, 32'h5A);
        rd(8'h04, 32'h33);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h0);
        wr(8'h04, 32'hFF);
        rd(8'h04, 32'h33);
    end
    endtask

    task automatic t_irq;
    begin
        src.fire(EVT_TA, 8'h00);
        wr(8'h0C, 32'h01);
        wr(8'h08, 32'h80);
        irq(1'b0);
        wr(8'h08, 32'h40);
        irq(1'b0);
        wr(8'h08, 32'hC0);
        irq(1'b1);
        wr(8'h04, 32'h0);
        irq(1'b0);
        src.set_two(8'h20);
        wr(8'h00, 32'hFF);
        irq(1'b0);
        src.set_two(8'h01);
        irq(1'b1);
        wr(8'h08, 32'h80);
        irq(1'b0);
        rd(8'h08, 32'h80);
        rd(8'h0C, 32'h01);
    end
    endtask

    task automatic t_event;
    begin
        wr(8'h1C, 32'h3F);
        rd(8'h18, 32'h0);
        wr(8'h20, 32'h08);
        rd(8'h20, 32'h08);
        src.fire(EVT_COLL, 8'h00);
        repeat (2) @(negedge CLOCK);
        chk({31'h0, IRQ_EVENT}, 32'h1);
        wr(8'h1C, 32'h08);
        repeat (2) @(negedge CLOCK);
        chk({31'h0, IRQ_EVENT}, 32'h0);
        rd(8'hFC, 32'h0);
        chk({31'h0, err}, 32'h1);
    end
    endtask

    initial
    begin
        fail_count = 0;
        checks     = 0;
        cycles     = 0;
        ARST_N     = 1'b0;
        PSEL       = 1'b0;
        PENABLE    = 1'b0;
        PWRITE     = 1'b0;
        PADDR      = '0;
        PWDATA     = 32'h0;
        repeat (6) @(posedge CLOCK);
        ARST_N <= 1'b1;
        t_reset();
        t_enable_two();
        t_flags();
        t_clear();
        t_irq();
        t_event();
        end_of_test();
    end
endmodule
